// ===== rts_consts.svh
// Constants for the reset time-out sequencer
// Summary of operation
// - Power-on starts the power-up delay when enabled; core held in reset meanwhile.
// - Crystal modes count 1024 oscillator cycles after the power-up delay ends.
// - Core leaves reset when the start-up count, or the delay in RC mode, ends.
// - Reset pin held low past all time-outs; execution starts when it rises.
// - Crystal waits delay plus 1024 cycles, or 1024 only; RC never waits on wake.
// - Bit 0 is active-low brown-out flag, cleared by hardware, set by software.
// - With brown-out detection off the brown-out flag carries no meaning.
// - Bit 1 is active-low power-on flag, cleared only on power-on, set by software.
// - Power-on sets both time-out and power-down flags.
// - Brown-out, watchdog, wake and pin-in-sleep each set their own flag pattern.
// - Reset pin during normal operation leaves all four flags unchanged.
// - Resets load program counter zero; wake-ups continue at program counter plus one.
// - Interrupt wake with global interrupt enable loads the interrupt vector.
// - Power-on gives status top bits 00011 and cause bits 0x; brown-out u0.
// - Three initialization classes: power-on or brown-out, pin or watchdog, wake-up.
// - Power-up delay is 72 ms, only after power-on or brown-out.
// - Start-up count runs only in crystal modes after power-on, brown-out or wake-up.
// - Brown-out detection enabled forces the power-up delay on.
`ifndef RTS_CONSTS_SVH
`define RTS_CONSTS_SVH
`define RTS_ADDR_CAUSE 8'h00
`define RTS_ADDR_STATE 8'h04
`define RTS_ADDR_EVT_STS 8'h08
`define RTS_ADDR_EVT_CLR 8'h0c
`define RTS_ADDR_EVT_EN 8'h10
`define RTS_CAUSE_BOR_BIT 0
`define RTS_CAUSE_POR_BIT 1
`define RTS_POWERUP_DELAY_TIMER_MS 72
`define RTS_CLK_KHZ 250000
`define RTS_OST_CYCLES 1024
`define RTS_PC_RESET 13'h0000
`define RTS_PC_IRQ_VEC 13'h0004
`define RTS_CLS_POWER 2'h0
`define RTS_CLS_RESET 2'h1
`define RTS_CLS_WAKE 2'h2
`define RTS_EVT_POR 0
`define RTS_EVT_BOR 1
`define RTS_EVT_PIN 2
`define RTS_EVT_WDT 3
`define RTS_EVT_WAKE 4
`define RTS_RESP_OKAY 2'h0
`define RTS_RESP_SLVERR 2'h2
`endif

// ===== rts_pkg.sv
// Types for the reset time-out sequencer
package rts_pkg;
    typedef enum logic [5:0] {
        ST_HOLD = 6'h01,
        ST_POWERUP_DELAY_TIMER = 6'h02,
        ST_OST = 6'h04,
        ST_WAIT_PIN = 6'h08,
        ST_RUN = 6'h10,
        ST_SLEEP = 6'h20
    } rts_state_type;

    typedef enum logic [1:0] {
        CAUSE_POR = 2'h0,
        CAUSE_BOR = 2'h1,
        CAUSE_RESET = 2'h2,
        CAUSE_WAKE = 2'h3
    } rts_cause_type;
endpackage : rts_pkg

// ===== rts_top.sv
// Reset time-out sequencer with reset-cause flags and AXI4-Lite registers
`timescale 1ns/1ns
`include "rts_consts.svh"
module rts_top #(
    parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `RTS_POWERUP_DELAY_TIMER_MS * `RTS_CLK_KHZ
) (
    input logic ref_clk_i,
    input logic rst_n_i,
    input logic clk_en_i,
    input logic por_i,
    input logic bor_i,
    input logic ext_reset_pin_n_i,
    input logic wdt_timeout_i,
    input logic irq_wake_i,
    input logic sleep_i,
    input logic osc_tick_i,
    input logic powerup_delay_enable_n_i,
    input logic brownout_detect_enable_i,
    input logic [1:0] osc_mode_i,
    input logic global_irq_enable_i,
    input logic [12:0] pc_i,
    output logic core_reset_n_o,
    output logic core_hold_o,
    output logic pc_load_o,
    output logic [12:0] pc_value_o,
    output logic [1:0] init_class_o,
    output logic timeout_flag_n_o,
    output logic powerdown_flag_n_o,
    output logic irq_o,
    input logic [7:0] s_axi_awaddr_i,
    input logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input logic [31:0] s_axi_wdata_i,
    input logic [3:0] s_axi_wstrb_i,
    input logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input logic s_axi_bready_i,
    input logic [7:0] s_axi_araddr_i,
    input logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input logic s_axi_rready_i
);
    localparam logic [24:0] POWERUP_DELAY_TIMER_LAST = 25'(POWERUP_DELAY_TIMER_CYCLES - 1);
    localparam logic [24:0] OST_LAST = 25'(`RTS_OST_CYCLES - 1);
    localparam logic [1:0] MODE_RC = 2'h3;

    typedef struct packed {
        rts_pkg::rts_state_type state;
        rts_pkg::rts_cause_type cause;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [24:0] cnt;
        logic to_n;
        logic pd_n;
        logic [1:0] prc;
        logic [12:0] pc_tgt;
        logic [1:0] cls;
        logic core_rst_n;
        logic core_hold;
        logic pc_load;
        logic [12:0] pc_val;
        logic [4:0] evt_sts;
        logic [4:0] evt_en;
        logic irq;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rts_regs_type;

    localparam rts_regs_type RESET_VAL = '{
        state: rts_pkg::ST_HOLD,
        cause: rts_pkg::CAUSE_POR,
        sync1: 3'h4,
        sync2: 3'h4,
        cnt: 25'h0,
        to_n: 1'b1,
        pd_n: 1'b1,
        prc: 2'h1,
        pc_tgt: `RTS_PC_RESET,
        cls: `RTS_CLS_POWER,
        core_rst_n: 1'b0,
        core_hold: 1'b1,
        pc_load: 1'b0,
        pc_val: `RTS_PC_RESET,
        evt_sts: 5'h01,
        evt_en: 5'h00,
        irq: 1'b0,
        awready: 1'b1,
        wready: 1'b1,
        aw_got: 1'b0,
        w_got: 1'b0,
        awaddr: 8'h00,
        wdata: 32'h0,
        wstrb0: 1'b0,
        bvalid: 1'b0,
        bresp: `RTS_RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rdata: 32'h0,
        rresp: `RTS_RESP_OKAY
    };

    rts_regs_type q;
    rts_regs_type d;
    logic por_p;
    logic bor_hi;
    logic pin_lo;
    logic crystal;
    logic powerup_delay_timer_on;
    logic [4:0] evt;
    logic [4:0] evt_clr;
    logic wr_ok;
    logic rd_ok;

    ////////////////////////////////////////////////////////////////////////
    // Reset source qualification
    assign por_p = q.sync2[0];
    assign bor_hi = q.sync2[1] & brownout_detect_enable_i;
    assign pin_lo = ~q.sync2[2];
    assign crystal = (osc_mode_i != MODE_RC);
    assign powerup_delay_timer_on = ~powerup_delay_enable_n_i | brownout_detect_enable_i;

    always_comb
    begin
        d = q;
        evt = 5'h00;
        evt_clr = 5'h00;
        d.pc_load = 1'b0;
        // Two-flop synchronizers for asynchronous requests
        d.sync1 = {ext_reset_pin_n_i, bor_i, por_i};
        d.sync2 = q.sync1;

        ////////////////////////////////////////////////////////////////////
        // Register writes
        if (s_axi_awvalid_i && q.awready)
        begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && q.wready)
        begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata_i;
            d.wstrb0 = s_axi_wstrb_i[0];
        end
        if (s_axi_bready_i && q.bvalid)
        begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid)
        begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            wr_ok = 1'b1;
            unique case (q.awaddr)
                `RTS_ADDR_CAUSE:
                begin
                    if (q.wstrb0)
                    begin
                        d.prc = q.wdata[1:0];
                    end
                end
                `RTS_ADDR_EVT_CLR:
                begin
                    if (q.wstrb0)
                    begin
                        evt_clr = q.wdata[4:0];
                    end
                end
                `RTS_ADDR_EVT_EN:
                begin
                    if (q.wstrb0)
                    begin
                        d.evt_en = q.wdata[4:0];
                    end
                end
                `RTS_ADDR_STATE, `RTS_ADDR_EVT_STS:
                begin
                    wr_ok = 1'b1;
                end
                default:
                begin
                    wr_ok = 1'b0;
                end
            endcase
            d.bresp = wr_ok ? `RTS_RESP_OKAY : `RTS_RESP_SLVERR;
        end
        else
        begin
            wr_ok = 1'b0;
        end
        d.awready = ~d.aw_got & ~d.bvalid;
        d.wready = ~d.w_got & ~d.bvalid;

        ////////////////////////////////////////////////////////////////////
        // Register reads
        if (s_axi_rready_i && q.rvalid)
        begin
            d.rvalid = 1'b0;
        end
        rd_ok = 1'b1;
        if (s_axi_arvalid_i && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata = 32'h0;
            unique case (s_axi_araddr_i)
                `RTS_ADDR_CAUSE: d.rdata[1:0] = q.prc;
                `RTS_ADDR_STATE: d.rdata[13:0] = {q.state, 5'h00, q.core_rst_n, q.pd_n, q.to_n};
                `RTS_ADDR_EVT_STS: d.rdata[4:0] = q.evt_sts;
                `RTS_ADDR_EVT_EN: d.rdata[4:0] = q.evt_en;
                `RTS_ADDR_EVT_CLR: d.rdata = 32'h0;
                default: rd_ok = 1'b0;
            endcase
            d.rresp = rd_ok ? `RTS_RESP_OKAY : `RTS_RESP_SLVERR;
        end
        d.arready = ~d.rvalid;

        ////////////////////////////////////////////////////////////////////
        // Time-out sequence; hardware flag updates win over software writes
        if (por_p)
        begin
            d.prc[`RTS_CAUSE_POR_BIT] = 1'b0;
            d.to_n = 1'b1;
            d.pd_n = 1'b1;
            d.cause = rts_pkg::CAUSE_POR;
            d.state = rts_pkg::ST_HOLD;
            d.cnt = 25'h0;
            d.core_rst_n = 1'b0;
            d.pc_tgt = `RTS_PC_RESET;
            d.cls = `RTS_CLS_POWER;
            evt[`RTS_EVT_POR] = 1'b1;
        end
        else if (bor_hi)
        begin
            d.prc[`RTS_CAUSE_BOR_BIT] = 1'b0;
            d.to_n = 1'b1;
            d.pd_n = 1'b1;
            d.cause = rts_pkg::CAUSE_BOR;
            d.state = rts_pkg::ST_HOLD;
            d.cnt = 25'h0;
            d.core_rst_n = 1'b0;
            d.pc_tgt = `RTS_PC_RESET;
            d.cls = `RTS_CLS_POWER;
            evt[`RTS_EVT_BOR] = (q.state != rts_pkg::ST_HOLD);
        end
        else
        begin
            unique case (q.state)
                rts_pkg::ST_HOLD:
                begin
                    d.cnt = 25'h0;
                    if (powerup_delay_timer_on || q.cause == rts_pkg::CAUSE_BOR)
                    begin
                        d.state = rts_pkg::ST_POWERUP_DELAY_TIMER;
                    end
                    else if (crystal)
                    begin
                        d.state = rts_pkg::ST_OST;
                    end
                    else
                    begin
                        d.state = rts_pkg::ST_WAIT_PIN;
                    end
                end
                rts_pkg::ST_POWERUP_DELAY_TIMER:
                begin
                    d.cnt = q.cnt + 25'h1;
                    if (q.cnt == POWERUP_DELAY_TIMER_LAST)
                    begin
                        d.cnt = 25'h0;
                        d.state = crystal ? rts_pkg::ST_OST : rts_pkg::ST_WAIT_PIN;
                    end
                end
                rts_pkg::ST_OST:
                begin
                    if (osc_tick_i)
                    begin
                        d.cnt = q.cnt + 25'h1;
                        if (q.cnt == OST_LAST)
                        begin
                            d.cnt = 25'h0;
                            d.state = rts_pkg::ST_WAIT_PIN;
                        end
                    end
                end
                rts_pkg::ST_WAIT_PIN:
                begin
                    if (!pin_lo)
                    begin
                        d.state = rts_pkg::ST_RUN;
                        d.core_rst_n = 1'b1;
                        d.pc_load = 1'b1;
                        d.pc_val = q.pc_tgt;
                    end
                end
                rts_pkg::ST_RUN:
                begin
                    if (pin_lo)
                    begin
                        d.state = rts_pkg::ST_WAIT_PIN;
                        d.cause = rts_pkg::CAUSE_RESET;
                        d.core_rst_n = 1'b0;
                        d.pc_tgt = `RTS_PC_RESET;
                        d.cls = `RTS_CLS_RESET;
                        evt[`RTS_EVT_PIN] = 1'b1;
                    end
                    else if (wdt_timeout_i)
                    begin
                        d.to_n = 1'b0;
                        d.pd_n = 1'b1;
                        d.state = rts_pkg::ST_WAIT_PIN;
                        d.cause = rts_pkg::CAUSE_RESET;
                        d.core_rst_n = 1'b0;
                        d.pc_tgt = `RTS_PC_RESET;
                        d.cls = `RTS_CLS_RESET;
                        evt[`RTS_EVT_WDT] = 1'b1;
                    end
                    else if (sleep_i)
                    begin
                        d.state = rts_pkg::ST_SLEEP;
                        d.to_n = 1'b1;
                        d.pd_n = 1'b0;
                    end
                end
                rts_pkg::ST_SLEEP:
                begin
                    if (pin_lo)
                    begin
                        d.to_n = 1'b1;
                        d.pd_n = 1'b0;
                        d.state = rts_pkg::ST_WAIT_PIN;
                        d.cause = rts_pkg::CAUSE_RESET;
                        d.core_rst_n = 1'b0;
                        d.pc_tgt = `RTS_PC_RESET;
                        d.cls = `RTS_CLS_RESET;
                        evt[`RTS_EVT_PIN] = 1'b1;
                    end
                    else if (wdt_timeout_i || irq_wake_i)
                    begin
                        d.to_n = ~wdt_timeout_i;
                        d.pd_n = 1'b0;
                        d.cause = rts_pkg::CAUSE_WAKE;
                        d.cls = `RTS_CLS_WAKE;
                        d.cnt = 25'h0;
                        d.state = crystal ? rts_pkg::ST_OST : rts_pkg::ST_WAIT_PIN;
                        if (!wdt_timeout_i && global_irq_enable_i)
                        begin
                            d.pc_tgt = `RTS_PC_IRQ_VEC;
                        end
                        else
                        begin
                            d.pc_tgt = pc_i + 13'h1;
                        end
                        evt[`RTS_EVT_WAKE] = 1'b1;
                    end
                end
            endcase
        end
        d.core_hold = (d.state != rts_pkg::ST_RUN) && (d.state != rts_pkg::ST_SLEEP);

        ////////////////////////////////////////////////////////////////////
        // Interrupt status, set wins over clear
        d.evt_sts = (q.evt_sts & ~evt_clr) | evt;
        d.irq = |(d.evt_sts & d.evt_en);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            q <= RESET_VAL;
        end
        else if (clk_en_i)
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign core_reset_n_o = q.core_rst_n;
    assign core_hold_o = q.core_hold;
    assign pc_load_o = q.pc_load;
    assign pc_value_o = q.pc_val;
    assign init_class_o = q.cls;
    assign timeout_flag_n_o = q.to_n;
    assign powerdown_flag_n_o = q.pd_n;
    assign irq_o = q.irq;
    assign s_axi_awready_o = q.awready;
    assign s_axi_wready_o = q.wready;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_arready_o = q.arready;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;
    assign s_axi_rvalid_o = q.rvalid;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i || !clk_en_i);

    a_por_flags_set: assert property (por_p |=> !q.prc[1] && q.to_n && q.pd_n)
        else $error("power-on did not set flags");
    a_powerup_delay_timer_entry: assert property (q.state == rts_pkg::ST_HOLD && !por_p && !bor_hi && powerup_delay_timer_on
        |=> q.state == rts_pkg::ST_POWERUP_DELAY_TIMER && q.core_hold)
        else $error("power-up delay not started");
    a_ost_length: assert property (q.state == rts_pkg::ST_OST && osc_tick_i && q.cnt == OST_LAST
        && !por_p && !bor_hi |=> q.state == rts_pkg::ST_WAIT_PIN)
        else $error("start-up count wrong length");
    a_pin_release: assert property (q.state == rts_pkg::ST_WAIT_PIN && !pin_lo && !por_p && !bor_hi
        |=> q.pc_load && !q.core_hold ##1 !q.pc_load)
        else $error("release on pin high missing");
    a_wdt_flags: assert property (q.state == rts_pkg::ST_RUN && wdt_timeout_i && !pin_lo && !por_p
        && !bor_hi |=> !q.to_n && q.pd_n && q.cls == `RTS_CLS_RESET)
        else $error("watchdog flags wrong");
    a_pin_keeps_flags: assert property (q.state == rts_pkg::ST_RUN && pin_lo && !por_p && !bor_hi
        && !(q.aw_got && q.w_got && !q.bvalid) |=> $stable(q.prc) && $stable(q.to_n) && $stable(q.pd_n))
        else $error("pin reset changed flags");
    a_reset_pc_zero: assert property (q.pc_load && q.cls != `RTS_CLS_WAKE |-> q.pc_val == `RTS_PC_RESET)
        else $error("reset did not load zero");
    a_irq_vector: assert property (q.state == rts_pkg::ST_SLEEP && irq_wake_i && !wdt_timeout_i && !pin_lo
        && !por_p && !bor_hi && global_irq_enable_i |=> q.pc_tgt == `RTS_PC_IRQ_VEC)
        else $error("interrupt vector not loaded");
    a_bor_flag_clr: assert property (bor_hi && !por_p |=> !q.prc[0] && q.to_n && q.pd_n)
        else $error("brown-out flags wrong");
    a_irq_level: assert property (##1 q.irq == |(q.evt_sts & q.evt_en))
        else $error("interrupt output mismatch");

    c_power_release: cover property (q.state == rts_pkg::ST_WAIT_PIN && q.cls == `RTS_CLS_POWER ##1 q.pc_load);
    c_irq_wake: cover property (q.pc_load && q.cls == `RTS_CLS_WAKE && q.pc_val == `RTS_PC_IRQ_VEC);
    c_pin_in_run: cover property (q.state == rts_pkg::ST_RUN && pin_lo);
endmodule : rts_top

// ===== rts_src_model.sv
// Model of the reset pin, supply detectors and oscillator input
`timescale 1ns/1ns
module rts_src_model (
    input wire logic ref_clk_i,
    output logic osc_tick_o,
    output logic ext_reset_pin_n_o,
    output logic por_o,
    output logic bor_o
);
    initial
    begin
        osc_tick_o = 1'b0;
        ext_reset_pin_n_o = 1'b0;
        por_o = 1'b0;
        bor_o = 1'b0;
    end
    // Pin may be held low past every time-out
    task automatic set_pin(input logic lvl);
        ext_reset_pin_n_o <= lvl;
    endtask : set_pin
    // Supply-low level
    task automatic set_bor(input logic lvl);
        bor_o <= lvl;
    endtask : set_bor
    // Power-on detector pulse, one cycle wide
    task automatic por_pulse;
        por_o <= 1'b1;
        @(posedge ref_clk_i);
        por_o <= 1'b0;
    endtask : por_pulse
    // Oscillator input cycles, one pulse each
    task automatic ticks(input int n);
        repeat (n)
        begin
            osc_tick_o <= 1'b1;
            @(posedge ref_clk_i);
            osc_tick_o <= 1'b0;
            @(posedge ref_clk_i);
        end
    endtask : ticks
endmodule : rts_src_model

// ===== rts_top_tb.sv
// Testbench for the reset time-out sequencer
`timescale 1ns/1ns
module rts_top_tb;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1;
    logic wdt_timeout_i = 1'b0, irq_wake_i = 1'b0, sleep_i = 1'b0;
    logic powerup_delay_enable_n_i = 1'b0, brownout_detect_enable_i = 1'b0, global_irq_enable_i = 1'b0;
    logic [1:0] osc_mode_i = 2'h1;
    logic [12:0] pc_i = 13'h0123;
    logic osc_tick_i, ext_reset_pin_n_i, por_i, bor_i;
    logic core_reset_n_o, core_hold_o, pc_load_o, timeout_flag_n_o, powerdown_flag_n_o, irq_o;
    logic [12:0] pc_value_o;
    logic [1:0] init_class_o;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_cycle = 0;
    rts_top #(.POWERUP_DELAY_TIMER_CYCLES(20)) dut (.ref_clk_i, .rst_n_i, .clk_en_i, .por_i, .bor_i, .ext_reset_pin_n_i,
        .wdt_timeout_i, .irq_wake_i, .sleep_i, .osc_tick_i, .powerup_delay_enable_n_i, .brownout_detect_enable_i,
        .osc_mode_i, .global_irq_enable_i, .pc_i, .core_reset_n_o, .core_hold_o, .pc_load_o, .pc_value_o,
        .init_class_o, .timeout_flag_n_o, .powerdown_flag_n_o, .irq_o, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);
    rts_src_model src (.ref_clk_i(ref_clk_i), .osc_tick_o(osc_tick_i), .ext_reset_pin_n_o(ext_reset_pin_n_i),
        .por_o(por_i), .bor_o(bor_i));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    always @(posedge ref_clk_i)
    begin
        n_cycle++;
        if (n_cycle == 40000)
        begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    ////////////////////////////////////////////////////////////////////////
    // Register bus accesses
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o)
                s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o)
                s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b0;
        chk(32'(s_axi_bresp_o), 32'(er));
        @(posedge ref_clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (s_axi_arvalid_i && s_axi_arready_o)
                s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b0;
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        @(posedge ref_clk_i);
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk(32'(r), 32'h0);
    endtask : rdc
    task automatic wait_state(input logic [5:0] s);
        logic [31:0] d;
        logic [1:0] r;
        do
            rd(8'h04, d, r);
        while (d[13:8] !== s);
    endtask : wait_state
    ////////////////////////////////////////////////////////////////////////
    // Core-side checks
    task automatic ld(input logic [12:0] pc, input logic [1:0] cls);
        do
            @(negedge ref_clk_i);
        while (pc_load_o !== 1'b1);
        chk(32'(pc_value_o), 32'(pc));
        chk(32'(init_class_o), 32'(cls));
        chk(32'(core_reset_n_o), 32'h1);
        @(posedge ref_clk_i);
    endtask : ld
    task automatic fl(input logic [1:0] e);
        chk(32'({timeout_flag_n_o, powerdown_flag_n_o}), 32'(e));
    endtask : fl
    task automatic pulse(input int k);
        wdt_timeout_i <= (k == 0);
        sleep_i <= (k == 1);
        irq_wake_i <= (k == 2);
        @(posedge ref_clk_i);
        wdt_timeout_i <= 1'b0;
        sleep_i <= 1'b0;
        irq_wake_i <= 1'b0;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wait_state(6'h02);
        chk(32'(core_reset_n_o), 32'h0);
        wait_state(6'h04);
        src.ticks(1023);
        rdc(8'h04, 32'h0403);
        src.ticks(1);
        repeat (4) @(posedge ref_clk_i);
        rdc(8'h04, 32'h0803);
        src.set_pin(1'b1);
        ld(13'h0000, 2'h0);
        fl(2'h3);
        rdc(8'h00, 32'h1);
        rdc(8'h08, 32'h1);
        wr(8'h00, 32'h3, 2'h0);
        rdc(8'h00, 32'h3);
        s_axi_wstrb_i <= 4'he;
        wr(8'h00, 32'h0, 2'h0);
        s_axi_wstrb_i <= 4'hf;
        rdc(8'h00, 32'h3);
        src.set_pin(1'b0);
        repeat (6) @(posedge ref_clk_i);
        src.set_pin(1'b1);
        ld(13'h0000, 2'h1);
        fl(2'h3);
        rdc(8'h00, 32'h3);
        wr(8'h10, 32'h4, 2'h0);
        repeat (2) @(posedge ref_clk_i);
        chk(32'(irq_o), 32'h1);
        wr(8'h0c, 32'h4, 2'h0);
        repeat (2) @(posedge ref_clk_i);
        chk(32'(irq_o), 32'h0);
        rdc(8'h08, 32'h1);
        pulse(0);
        ld(13'h0000, 2'h1);
        fl(2'h1);
        for (int m = 0; m < 3; m++)
        begin
            osc_mode_i <= 2'(m);
            pc_i <= 13'h1ffe + 13'(m);
            pulse(1);
            wait_state(6'h20);
            pulse(0);
            wait_state(6'h04);
            src.ticks(1024);
            ld(pc_i + 13'h1, 2'h2);
            fl(2'h0);
        end
        osc_mode_i <= 2'h3;
        for (int g = 1; g >= 0; g--)
        begin
            global_irq_enable_i <= 1'(g);
            pulse(1);
            wait_state(6'h20);
            pulse(2);
            ld((g == 1) ? 13'h0004 : pc_i + 13'h1, 2'h2);
            fl(2'h2);
        end
        brownout_detect_enable_i <= 1'b1;
        powerup_delay_enable_n_i <= 1'b1;
        src.set_bor(1'b1);
        repeat (8) @(posedge ref_clk_i);
        src.set_bor(1'b0);
        wait_state(6'h02);
        ld(13'h0000, 2'h0);
        fl(2'h3);
        rdc(8'h00, 32'h2);
        brownout_detect_enable_i <= 1'b0;
        osc_mode_i <= 2'h1;
        src.por_pulse();
        repeat (4) @(posedge ref_clk_i);
        rdc(8'h04, 32'h0403);
        src.ticks(1024);
        ld(13'h0000, 2'h0);
        fl(2'h3);
        rdc(8'h00, 32'h0);
        clk_en_i <= 1'b0;
        pulse(0);
        clk_en_i <= 1'b1;
        @(negedge ref_clk_i);
        fl(2'h3);
        @(posedge ref_clk_i);
        wr(8'h08, 32'h0, 2'h0);
        rdc(8'h08, 32'h1b);
        rdc(8'h10, 32'h4);
        wr(8'h14, 32'h1, 2'h2);
        rd(8'h14, d, r);
        chk(32'(r), 32'h2);
        complete_run();
    end
endmodule : rts_top_tb
